// ===== common/pmc_pkg.sv
// constants, types and register map of the power mode controller
package pmc_pkg;

  // =====================================================
  // timing
  localparam int unsigned CLK_PERIOD_NS = 20;
  localparam int unsigned SLEEP_WAKE_NS = 15000;
  localparam int unsigned HIB_WAKE_NS   = 100000;
  // longest times round down, one cycle kept back so the wake ends strictly under
  localparam int unsigned SLEEP_WAKE_CYC = SLEEP_WAKE_NS / CLK_PERIOD_NS - 1;
  localparam int unsigned HIB_WAKE_CYC   = HIB_WAKE_NS / CLK_PERIOD_NS - 1;
  localparam int unsigned BUZZ_PERIOD_CYC = 64;
  localparam int unsigned BUZZ_ON_CYC     = 8;

  // =====================================================
  // register offsets
  localparam logic [7:0] ADDR_MODE     = 8'h00;
  localparam logic [7:0] ADDR_ACT_TMPL = 8'h04;
  localparam logic [7:0] ADDR_ALT_TMPL = 8'h08;
  localparam logic [7:0] ADDR_WAKE_EN  = 8'h0c;
  localparam logic [7:0] ADDR_STATUS   = 8'h10;

  // =====================================================
  // wake sources, one bit each
  localparam int unsigned NSRC       = 7;
  localparam int unsigned SRC_COMP   = 0;
  localparam int unsigned SRC_PIN    = 1;
  localparam int unsigned SRC_I2C    = 2;
  localparam int unsigned SRC_RTC    = 3;
  localparam int unsigned SRC_TWHEEL = 4;
  localparam int unsigned SRC_VDET   = 5;
  localparam int unsigned SRC_PERIPH = 6;
  localparam logic [NSRC-1:0] SLEEP_SRC_MASK = 7'h3f;
  localparam logic [NSRC-1:0] WAKE_EN_RST    = 7'h00;

  // =====================================================
  // subsystem positions and field layout
  localparam int unsigned SUB_CPU   = 0;
  localparam int unsigned SUB_FLASH = 1;
  localparam int unsigned SUB_I2C   = 2;
  localparam int unsigned SUB_COMP  = 3;
  localparam int unsigned ST_MODE_LSB  = 0;
  localparam int unsigned ST_WAKE_BIT  = 2;
  localparam int unsigned ST_CAUSE_LSB = 8;

  // =====================================================
  // modes and controller states
  typedef enum logic [1:0] {
    MODE_ACTIVE = 2'h0,
    MODE_ALT    = 2'h1,
    MODE_SLEEP  = 2'h2,
    MODE_HIB    = 2'h3
  } pmc_mode_t;

  typedef enum logic [4:0] {
    ST_ACTIVE = 5'h01,
    ST_ALT    = 5'h02,
    ST_SLEEP  = 5'h04,
    ST_HIB    = 5'h08,
    ST_WAKE   = 5'h10
  } pmc_state_t;

endpackage : pmc_pkg

// ===== rtl/pmc_settle_timer.sv
// down counter that holds a wake sequence until regulators settle
`timescale 1ns/10ps
`default_nettype none
module pmc_settle_timer #(
  parameter int unsigned W = 16
) (
  input  wire logic         ref_clk, // system clock
  input  wire logic         nrst,    // async reset, low
  input  wire logic         start,   // load and run
  input  wire logic [W-1:0] load,    // cycles to wait
  output logic              busy,    // counting
  output logic              done     // last count cycle
);
  logic [W-1:0] cnt_reg;
  logic         busy_reg;

  // =====================================================
  // counter
  always_ff @(posedge ref_clk or negedge nrst) begin
    if (!nrst) begin
      cnt_reg  <= '0;
      busy_reg <= 1'b0;
    end else if (start) begin
      cnt_reg  <= load;
      busy_reg <= 1'b1;
    end else if (busy_reg) begin
      if (cnt_reg == '0) busy_reg <= 1'b0;
      else cnt_reg <= cnt_reg - 1'b1;
    end
  end

  assign busy = busy_reg;
  assign done = busy_reg && (cnt_reg == '0);
endmodule : pmc_settle_timer
`default_nettype wire

// ===== rtl/pmc_buzz_gen.sv
// periodic regulator enable for buzzed operation
`timescale 1ns/10ps
`default_nettype none
module pmc_buzz_gen #(
  parameter int unsigned PERIOD = 64,
  parameter int unsigned ON     = 8
) (
  input  wire logic ref_clk, // system clock
  input  wire logic nrst,    // async reset, low
  input  wire logic run,     // buzzing allowed
  output logic      buzz_on  // regulator on window
);
  localparam int unsigned CW = $clog2(PERIOD);
  logic [CW-1:0] cnt_reg;
  logic          on_reg;

  // =====================================================
  // parameter check
  initial begin
    if (ON == 0 || ON >= PERIOD || PERIOD < 2) $error("bad buzz timing");
  end

  // =====================================================
  // period counter and on window
  always_ff @(posedge ref_clk or negedge nrst) begin
    if (!nrst) begin
      cnt_reg <= '0;
      on_reg  <= 1'b0;
    end else if (!run) begin
      cnt_reg <= '0;
      on_reg  <= 1'b0;
    end else begin
      cnt_reg <= (cnt_reg == CW'(PERIOD - 1)) ? '0 : cnt_reg + 1'b1;
      on_reg  <= (cnt_reg < CW'(ON));
    end
  end

  assign buzz_on = on_reg;
endmodule : pmc_buzz_gen
`default_nettype wire

// ===== rtl/pmc_power_mode_ctrl.sv
// global power mode controller: modes, templates, wake and regulator control
//
// Behaviour
// - four modes: active, alternate active, sleep, hibernate, in falling consumption
// - active and alternate modes enable subsystems from their own template
// - template writes take effect at once while active
// - a disabled subsystem has clock gated and power reduction asserted
// - alternate mode uses its own template, may drop processor and flash
// - sleep disables most subsystems whatever the templates say
// - digital and analog regulators are buzzed during sleep
// - sleep wake waits for regulator settling, ends under fifteen microseconds
// - hibernate stops all clocks, only hibernate regulator stays on
// - hibernate keeps registers, memory, output pins and pin interrupt settings
// - only a pin interrupt wakes from hibernate
// - hibernate wake completes within one hundred microseconds
// - processor may turn itself off; next wake turns it back on
// - any wake forces active mode and enables the processor
// - after reset the mode is active
// - each wake interrupt source is enabled individually
// - timewheel periodic interrupt is a usable wake source
// - reset pin, watchdog, precise low voltage reset wake and reset the device
//
// The address-and-strobe port and the address map were left to the implementer.
`timescale 1ns/10ps
`default_nettype none
module pmc_power_mode_ctrl #(
  parameter int unsigned NSUB           = 8,
  parameter int unsigned SLEEP_WAKE_CYC = pmc_pkg::SLEEP_WAKE_CYC,
  parameter int unsigned HIB_WAKE_CYC   = pmc_pkg::HIB_WAKE_CYC,
  parameter int unsigned BUZZ_PERIOD    = pmc_pkg::BUZZ_PERIOD_CYC,
  parameter int unsigned BUZZ_ON        = pmc_pkg::BUZZ_ON_CYC
) (
  input  wire logic                     ref_clk,          // system clock
  input  wire logic                     nrst,             // async reset, low
  input  wire logic [7:0]               reg_addr,         // register byte address
  input  wire logic [31:0]              reg_wdata,        // write data
  input  wire logic                     reg_wr,           // write strobe
  input  wire logic                     reg_rd,           // read strobe
  output logic      [31:0]              reg_rdata,        // read data, next cycle
  input  wire logic [pmc_pkg::NSRC-1:0] wake_src,         // wake interrupt requests
  input  wire logic                     external_reset_pin, // reset pin event
  input  wire logic                     watchdog_reset_source, // watchdog event
  input  wire logic                     precise_low_voltage_reset, // supply event
  output logic      [1:0]               mode,             // global mode code
  output logic      [NSUB-1:0]          subsys_en,        // subsystem enables
  output logic      [NSUB-1:0]          subsys_clk_gate,  // clock gate, high gates
  output logic      [NSUB-1:0]          subsys_pwr_down,  // power reduction
  output logic                          dig_reg_en,       // digital regulator on
  output logic                          ana_reg_en,       // analog regulator on
  output logic                          hib_reg_en,       // hibernate regulator on
  output logic                          sleep_clk_sel,    // slow oscillator clocks
  output logic                          clocks_stop,      // all clocks stopped
  output logic                          io_hold,          // hold pins and settings
  output logic                          dev_reset_req     // device reset pulse
);
  localparam int unsigned TW = 16;
  localparam logic [TW-1:0] SLEEP_LOAD = TW'(SLEEP_WAKE_CYC - 2);
  localparam logic [TW-1:0] HIB_LOAD   = TW'(HIB_WAKE_CYC - 2);

  // =====================================================
  // parameter check
  initial begin
    if (NSUB < 4 || NSUB > 16) $error("NSUB out of range");
    if (SLEEP_WAKE_CYC < 3 || HIB_WAKE_CYC < 3) $error("wake count too small");
    if (HIB_WAKE_CYC > 65535 || SLEEP_WAKE_CYC > 65535) $error("wake count too large");
  end

  // =====================================================
  // mode code of a state
  function automatic logic [1:0] mode_of(input pmc_pkg::pmc_state_t s,
                                         input logic from_hib);
    logic [1:0] m;
    m = pmc_pkg::MODE_ACTIVE;
    unique case (s)
      pmc_pkg::ST_ACTIVE: m = pmc_pkg::MODE_ACTIVE;
      pmc_pkg::ST_ALT:    m = pmc_pkg::MODE_ALT;
      pmc_pkg::ST_SLEEP:  m = pmc_pkg::MODE_SLEEP;
      pmc_pkg::ST_HIB:    m = pmc_pkg::MODE_HIB;
      pmc_pkg::ST_WAKE:   m = from_hib ? pmc_pkg::MODE_HIB : pmc_pkg::MODE_SLEEP;
      default:            m = pmc_pkg::MODE_ACTIVE;
    endcase
    return m;
  endfunction : mode_of

  pmc_pkg::pmc_state_t state_reg, state_next;
  logic [NSUB-1:0]          act_tmpl_reg, alt_tmpl_reg, en_next;
  logic [pmc_pkg::NSRC-1:0] wake_en_reg, cause_reg, hit_vec;
  logic        from_hib_reg, rst_evt, wake_hit, wake_evt, mode_wr;
  logic        tmr_start, tmr_done, buzz_on;
  logic [TW-1:0] tmr_load;
  logic [NSUB-1:0] keep_mask;

  assign rst_evt = external_reset_pin | watchdog_reset_source
                 | precise_low_voltage_reset;
  assign mode_wr = reg_wr && (reg_addr == pmc_pkg::ADDR_MODE);

  // =====================================================
  // enabled wake causes for the present state
  always_comb begin
    hit_vec = '0;
    unique case (state_reg)
      pmc_pkg::ST_ACTIVE, pmc_pkg::ST_ALT:
        hit_vec = wake_src & wake_en_reg;
      pmc_pkg::ST_SLEEP:
        hit_vec = wake_src & wake_en_reg & pmc_pkg::SLEEP_SRC_MASK;
      pmc_pkg::ST_HIB:
        hit_vec[pmc_pkg::SRC_PIN] = wake_src[pmc_pkg::SRC_PIN]
                                  & wake_en_reg[pmc_pkg::SRC_PIN];
      pmc_pkg::ST_WAKE: hit_vec = '0;
      default:          hit_vec = '0;
    endcase
  end
  assign wake_hit = |hit_vec;

  // =====================================================
  // next state
  always_comb begin
    state_next = state_reg;
    tmr_start  = 1'b0;
    tmr_load   = SLEEP_LOAD;
    if (rst_evt) begin
      state_next = pmc_pkg::ST_ACTIVE;
    end else begin
      unique case (state_reg)
        pmc_pkg::ST_ACTIVE, pmc_pkg::ST_ALT: begin
          if (wake_hit) begin
            state_next = pmc_pkg::ST_ACTIVE;
          end else if (mode_wr) begin
            unique case (reg_wdata[1:0])
              pmc_pkg::MODE_ACTIVE: state_next = pmc_pkg::ST_ACTIVE;
              pmc_pkg::MODE_ALT:    state_next = pmc_pkg::ST_ALT;
              pmc_pkg::MODE_SLEEP:  state_next = pmc_pkg::ST_SLEEP;
              pmc_pkg::MODE_HIB:    state_next = pmc_pkg::ST_HIB;
            endcase
          end
        end
        pmc_pkg::ST_SLEEP: begin
          if (wake_hit) begin
            state_next = pmc_pkg::ST_WAKE;
            tmr_start  = 1'b1;
            tmr_load   = SLEEP_LOAD;
          end
        end
        pmc_pkg::ST_HIB: begin
          if (wake_hit) begin
            state_next = pmc_pkg::ST_WAKE;
            tmr_start  = 1'b1;
            tmr_load   = HIB_LOAD;
          end
        end
        pmc_pkg::ST_WAKE: begin
          if (tmr_done) state_next = pmc_pkg::ST_ACTIVE;
        end
        default: state_next = pmc_pkg::ST_ACTIVE;
      endcase
    end
  end

  // return to active that counts as a wake event
  assign wake_evt = rst_evt
                  || (wake_hit && (state_reg == pmc_pkg::ST_ACTIVE
                                   || state_reg == pmc_pkg::ST_ALT))
                  || (state_reg == pmc_pkg::ST_WAKE && tmr_done);

  // =====================================================
  // state register
  always_ff @(posedge ref_clk or negedge nrst) begin
    if (!nrst) begin
      state_reg    <= pmc_pkg::ST_ACTIVE;
      from_hib_reg <= 1'b0;
    end else begin
      state_reg <= state_next;
      if (tmr_start) from_hib_reg <= (state_reg == pmc_pkg::ST_HIB);
    end
  end

  // =====================================================
  // templates; a wake sets the processor bit over any write
  always_ff @(posedge ref_clk or negedge nrst) begin
    if (!nrst) begin
      act_tmpl_reg <= '1;
      alt_tmpl_reg <= '1;
      wake_en_reg  <= pmc_pkg::WAKE_EN_RST;
    end else if (rst_evt) begin
      act_tmpl_reg <= '1;
      alt_tmpl_reg <= '1;
      wake_en_reg  <= pmc_pkg::WAKE_EN_RST;
    end else begin
      if (reg_wr && reg_addr == pmc_pkg::ADDR_ACT_TMPL)
        act_tmpl_reg <= reg_wdata[NSUB-1:0];
      if (reg_wr && reg_addr == pmc_pkg::ADDR_ALT_TMPL)
        alt_tmpl_reg <= reg_wdata[NSUB-1:0];
      if (reg_wr && reg_addr == pmc_pkg::ADDR_WAKE_EN)
        wake_en_reg <= reg_wdata[pmc_pkg::NSRC-1:0];
      if (wake_evt) act_tmpl_reg[pmc_pkg::SUB_CPU] <= 1'b1;
    end
  end

  // =====================================================
  // sticky wake causes, write one to clear, set wins
  always_ff @(posedge ref_clk or negedge nrst) begin
    if (!nrst) begin
      cause_reg <= '0;
    end else begin
      cause_reg <= (cause_reg
                   & ~((reg_wr && reg_addr == pmc_pkg::ADDR_STATUS)
                       ? reg_wdata[pmc_pkg::ST_CAUSE_LSB +: pmc_pkg::NSRC] : '0))
                   | hit_vec;
    end
  end

  // =====================================================
  // settle timer and regulator buzz
  pmc_settle_timer #(.W(TW)) u_settle (
    .ref_clk (ref_clk),
    .nrst    (nrst),
    .start   (tmr_start),
    .load    (tmr_load),
    .busy    (),
    .done    (tmr_done)
  );

  pmc_buzz_gen #(.PERIOD(BUZZ_PERIOD), .ON(BUZZ_ON)) u_buzz (
    .ref_clk (ref_clk),
    .nrst    (nrst),
    .run     (state_reg == pmc_pkg::ST_SLEEP),
    .buzz_on (buzz_on)
  );

  // =====================================================
  // subsystem enables per state
  always_comb begin
    keep_mask = '0;
    keep_mask[pmc_pkg::SUB_I2C]  = 1'b1;
    keep_mask[pmc_pkg::SUB_COMP] = 1'b1;
    en_next = '0;
    unique case (state_reg)
      pmc_pkg::ST_ACTIVE: en_next = act_tmpl_reg;
      pmc_pkg::ST_ALT:    en_next = alt_tmpl_reg;
      pmc_pkg::ST_SLEEP:  en_next = keep_mask;
      pmc_pkg::ST_HIB:    en_next = '0;
      pmc_pkg::ST_WAKE:   en_next = '0;
      default:            en_next = '0;
    endcase
  end

  // =====================================================
  // registered power outputs
  always_ff @(posedge ref_clk or negedge nrst) begin
    if (!nrst) begin
      subsys_en       <= '1;
      subsys_clk_gate <= '0;
      subsys_pwr_down <= '0;
      mode            <= pmc_pkg::MODE_ACTIVE;
      dig_reg_en      <= 1'b1;
      ana_reg_en      <= 1'b1;
      hib_reg_en      <= 1'b1;
      sleep_clk_sel   <= 1'b0;
      clocks_stop     <= 1'b0;
      io_hold         <= 1'b0;
      dev_reset_req   <= 1'b0;
    end else begin
      subsys_en       <= en_next;
      subsys_clk_gate <= ~en_next;
      subsys_pwr_down <= ~en_next;
      mode            <= mode_of(state_reg, from_hib_reg);
      dig_reg_en      <= (state_reg == pmc_pkg::ST_SLEEP) ? buzz_on
                       : (state_reg != pmc_pkg::ST_HIB);
      ana_reg_en      <= (state_reg == pmc_pkg::ST_SLEEP) ? buzz_on
                       : (state_reg != pmc_pkg::ST_HIB);
      hib_reg_en      <= 1'b1;
      sleep_clk_sel   <= (state_reg == pmc_pkg::ST_SLEEP);
      clocks_stop     <= (state_reg == pmc_pkg::ST_HIB);
      io_hold         <= (state_reg == pmc_pkg::ST_HIB);
      dev_reset_req   <= rst_evt;
    end
  end

  // =====================================================
  // register read
  always_ff @(posedge ref_clk or negedge nrst) begin
    if (!nrst) begin
      reg_rdata <= '0;
    end else if (reg_rd) begin
      unique case (reg_addr)
        pmc_pkg::ADDR_MODE:     reg_rdata <= {30'h0, mode_of(state_reg, from_hib_reg)};
        pmc_pkg::ADDR_ACT_TMPL: reg_rdata <= 32'(act_tmpl_reg);
        pmc_pkg::ADDR_ALT_TMPL: reg_rdata <= 32'(alt_tmpl_reg);
        pmc_pkg::ADDR_WAKE_EN:  reg_rdata <= 32'(wake_en_reg);
        pmc_pkg::ADDR_STATUS:   reg_rdata <= {17'h0, cause_reg, 5'h0,
                                             state_reg == pmc_pkg::ST_WAKE,
                                             mode_of(state_reg, from_hib_reg)};
        default:                reg_rdata <= '0;
      endcase
    end else begin
      reg_rdata <= '0;
    end
  end

  // =====================================================
  // checks
  logic [TW-1:0] wake_cnt_reg;
  always_ff @(posedge ref_clk or negedge nrst) begin
    if (!nrst) wake_cnt_reg <= '0;
    else if (state_reg == pmc_pkg::ST_WAKE) wake_cnt_reg <= wake_cnt_reg + 1'b1;
    else wake_cnt_reg <= '0;
  end

  chk_state_onehot: assert property (
    @(posedge ref_clk) disable iff (!nrst) $onehot(state_reg))
    else $error("state not one-hot");

  chk_alt_template: assert property (
    @(posedge ref_clk) disable iff (!nrst)
    (state_reg == pmc_pkg::ST_ALT) [*2] |-> subsys_en == $past(alt_tmpl_reg))
    else $error("alternate template not applied");

  chk_gate_pair: assert property (
    @(posedge ref_clk) disable iff (!nrst)
    subsys_clk_gate == ~subsys_en && subsys_pwr_down == ~subsys_en)
    else $error("gate disagrees with enable");

  chk_sleep_buzz: assert property (
    @(posedge ref_clk) disable iff (!nrst)
    $past(state_reg == pmc_pkg::ST_SLEEP) && state_reg == pmc_pkg::ST_SLEEP
    |-> dig_reg_en == $past(buzz_on) && ana_reg_en == dig_reg_en)
    else $error("regulators not buzzed in sleep");

  chk_sleep_off: assert property (
    @(posedge ref_clk) disable iff (!nrst)
    $past(state_reg == pmc_pkg::ST_SLEEP) |-> subsys_en[pmc_pkg::SUB_CPU] == 1'b0)
    else $error("processor enabled in sleep");

  chk_hib_stop: assert property (
    @(posedge ref_clk) disable iff (!nrst)
    state_reg == pmc_pkg::ST_HIB |=> clocks_stop && io_hold && !dig_reg_en
                                     && hib_reg_en && subsys_en == '0)
    else $error("hibernate outputs wrong");

  chk_hib_pin_only: assert property (
    @(posedge ref_clk) disable iff (!nrst)
    state_reg == pmc_pkg::ST_HIB && !rst_evt && !wake_src[pmc_pkg::SRC_PIN]
    |=> state_reg == pmc_pkg::ST_HIB)
    else $error("hibernate left without pin");

  chk_wake_bound: assert property (
    @(posedge ref_clk) disable iff (!nrst)
    state_reg == pmc_pkg::ST_WAKE
    |-> wake_cnt_reg < TW'((from_hib_reg ? HIB_WAKE_CYC : SLEEP_WAKE_CYC) - 1))
    else $error("wake took too long");

  chk_cpu_rewake: assert property (
    @(posedge ref_clk) disable iff (!nrst)
    wake_evt |=> act_tmpl_reg[pmc_pkg::SUB_CPU] && state_reg == pmc_pkg::ST_ACTIVE)
    else $error("processor not re-enabled on wake");

  chk_reset_wake: assert property (
    @(posedge ref_clk) disable iff (!nrst)
    rst_evt |=> dev_reset_req && state_reg == pmc_pkg::ST_ACTIVE ##1
               mode == pmc_pkg::MODE_ACTIVE)
    else $error("reset source did not return to active");
endmodule : pmc_power_mode_ctrl
`default_nettype wire

// ===== verif/pmc_wake_model.sv
// wake event source model: raises one request line for a few cycles
`timescale 1ns/10ps
`default_nettype none
module pmc_wake_model #(
  parameter int unsigned HOLD = 3
) (
  input  wire logic                     ref_clk,  // system clock
  input  wire logic                     fire,     // start one request
  input  wire logic [2:0]               fire_idx, // source number
  output logic      [pmc_pkg::NSRC-1:0] wake_src  // request lines
);
  int unsigned left = 0;
  initial wake_src = '0;
  // =====================================================
  // level request held for HOLD cycles, then dropped low
  always @(posedge ref_clk) begin
    if (fire) begin
      wake_src <= pmc_pkg::NSRC'(1) << fire_idx;
      left <= HOLD;
    end else if (left > 1) begin
      left <= left - 1;
    end else begin
      wake_src <= '0;
    end
  end
endmodule : pmc_wake_model
`default_nettype wire

// ===== verif/pmc_power_mode_ctrl_test.sv
// self-checking bench of the power mode controller
`timescale 1ns/10ps
`default_nettype none
module pmc_power_mode_ctrl_test;
  localparam int unsigned SW = 10;
  localparam int unsigned HW = 20;
  logic ref_clk, nrst, reg_wr, reg_rd, fire, rd_d = 0;
  logic [7:0]  reg_addr, val;
  logic [31:0] reg_wdata, reg_rdata;
  logic [2:0]  rst_ev, fire_idx;
  logic [1:0]  mode;
  logic [7:0]  subsys_en, subsys_clk_gate, subsys_pwr_down;
  logic        dig_reg_en, ana_reg_en, hib_reg_en, sleep_clk_sel, clocks_stop, io_hold;
  logic        dev_reset_req, seen;
  logic [pmc_pkg::NSRC-1:0] wake_src;
  logic [31:0] exp_q[$];
  int          n_mismatch = 0, num_checks = 0, n, cnt;
  pmc_power_mode_ctrl #(.SLEEP_WAKE_CYC(SW), .HIB_WAKE_CYC(HW)) uut (
    .ref_clk, .nrst, .reg_addr, .reg_wdata, .reg_wr, .reg_rd, .reg_rdata, .wake_src,
    .external_reset_pin(rst_ev[0]), .watchdog_reset_source(rst_ev[1]),
    .precise_low_voltage_reset(rst_ev[2]), .mode, .subsys_en, .subsys_clk_gate,
    .subsys_pwr_down, .dig_reg_en, .ana_reg_en, .hib_reg_en, .sleep_clk_sel,
    .clocks_stop, .io_hold, .dev_reset_req);
  pmc_wake_model srcs (.ref_clk, .fire, .fire_idx, .wake_src);
  // =====================================================
  // clock and helpers
  always #10 ref_clk = ~ref_clk;
  task automatic check(input logic [31:0] s, input logic [31:0] e);
    num_checks++;
    if (s !== e) begin
      n_mismatch++;
      $display("mismatch at %0t seen %h expected %h", $time, s, e);
    end
  endtask : check
  task automatic stop_test();
    $display("checks %0d mismatches %0d", num_checks, n_mismatch);
    if (n_mismatch == 0 && num_checks > 0) $display("TB: PASS");
    else $display("TB: FAIL");
    $finish;
  endtask : stop_test
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    reg_addr <= a;
    reg_wdata <= d;
    reg_wr <= 1'b1;
    @(posedge ref_clk);
    reg_wr <= 1'b0;
    repeat (2) @(posedge ref_clk);
  endtask : wr
  task automatic rd(input logic [7:0] a, input logic [31:0] e);
    reg_addr <= a;
    reg_rd <= 1'b1;
    exp_q.push_back(e);
    @(posedge ref_clk);
    reg_rd <= 1'b0;
    @(posedge ref_clk);
  endtask : rd
  task automatic fire_src(input int i);
    fire_idx <= 3'(i);
    fire <= 1'b1;
    @(posedge ref_clk);
    fire <= 1'b0;
  endtask : fire_src
  task automatic wait_mode(input logic [1:0] m, input int bound);
    n = 0;
    while (mode !== m) begin
      @(posedge ref_clk);
      n++;
      if (n > bound) begin
        check(mode, m);
        stop_test();
      end
    end
  endtask : wait_mode
  // =====================================================
  // read watcher: compares data of the cycle after each read
  always @(posedge ref_clk) begin
    if (rd_d) check(reg_rdata, exp_q.pop_front());
    rd_d <= reg_rd;
  end
  // =====================================================
  // main sequence
  initial begin
    ref_clk = 0;
    {nrst, reg_wr, reg_rd, fire, fire_idx, rst_ev, reg_addr, reg_wdata} <= '0;
    void'($urandom(32'h8f43));
    repeat (2) @(posedge ref_clk);
    nrst <= 1'b1;
    @(posedge ref_clk);
    check(mode, pmc_pkg::MODE_ACTIVE);
    check({hib_reg_en, subsys_en}, 9'h1ff);
    rd(pmc_pkg::ADDR_ACT_TMPL, 32'hff);
    rd(pmc_pkg::ADDR_WAKE_EN, 32'h0);
    $display("test reset done");
    val = 8'($urandom) & 8'hfe;
    wr(pmc_pkg::ADDR_ACT_TMPL, {24'h0, val});
    check(subsys_en, val);
    check({subsys_clk_gate, subsys_pwr_down}, {~val, ~val});
    wr(pmc_pkg::ADDR_ALT_TMPL, 32'hfc);
    wr(pmc_pkg::ADDR_MODE, 32'(pmc_pkg::MODE_ALT));
    check({mode, subsys_en}, {pmc_pkg::MODE_ALT, 8'hfc});
    wr(pmc_pkg::ADDR_WAKE_EN, 32'h1 << pmc_pkg::SRC_COMP);
    fire_src(pmc_pkg::SRC_COMP);
    wait_mode(pmc_pkg::MODE_ACTIVE, 20);
    repeat (2) @(posedge ref_clk);
    check(subsys_en, val | 8'h01);
    $display("test templates done");
    for (int i = 0; i < 6; i++) begin
      wr(pmc_pkg::ADDR_WAKE_EN, 32'h1 << i);
      wr(pmc_pkg::ADDR_MODE, 32'(pmc_pkg::MODE_SLEEP));
      fire_src((i + 1) % 6);
      repeat (5) @(posedge ref_clk);
      check(mode, pmc_pkg::MODE_SLEEP);
      check({sleep_clk_sel, subsys_en}, 9'h10c);
      cnt = 0;
      repeat (64) begin
        @(posedge ref_clk);
        cnt += dig_reg_en + ana_reg_en;
      end
      check(cnt, 2 * pmc_pkg::BUZZ_ON_CYC);
      fire_src(i);
      wait_mode(pmc_pkg::MODE_ACTIVE, SW + 10);
      // cause sampled at n = 1, mode register goes active the wake count later, seen here one cycle after
      check(n, SW + 2);
    end
    $display("test sleep done");
    wr(pmc_pkg::ADDR_WAKE_EN, 32'h3);
    wr(pmc_pkg::ADDR_MODE, 32'(pmc_pkg::MODE_HIB));
    check({clocks_stop, io_hold}, 2'h3);
    check({dig_reg_en, ana_reg_en, hib_reg_en, subsys_en}, 11'h100);
    fire_src(pmc_pkg::SRC_COMP);
    repeat (5) @(posedge ref_clk);
    check(mode, pmc_pkg::MODE_HIB);
    fire_src(pmc_pkg::SRC_PIN);
    wait_mode(pmc_pkg::MODE_ACTIVE, HW + 10);
    check(n, HW + 2);
    $display("test hibernate done");
    // causes 0 to 5 latched by the enabled wakes so far, then cleared
    rd(pmc_pkg::ADDR_STATUS, 32'h3f00);
    wr(pmc_pkg::ADDR_STATUS, 32'h3f00);
    rd(pmc_pkg::ADDR_STATUS, 32'h0);
    wr(pmc_pkg::ADDR_MODE, 32'(pmc_pkg::MODE_ALT));
    check(mode, pmc_pkg::MODE_ALT);
    wr(pmc_pkg::ADDR_MODE, 32'(pmc_pkg::MODE_ACTIVE));
    rd(pmc_pkg::ADDR_MODE, 32'(pmc_pkg::MODE_ACTIVE));
    $display("test status done");
    for (int k = 0; k < 3; k++) begin
      wr(pmc_pkg::ADDR_ACT_TMPL, 32'h0);
      wr(pmc_pkg::ADDR_MODE, 32'(pmc_pkg::MODE_SLEEP));
      rst_ev <= 3'h1 << k;
      @(posedge ref_clk);
      rst_ev <= 3'h0;
      seen = 0;
      repeat (4) begin
        @(posedge ref_clk);
        seen |= dev_reset_req;
      end
      check(seen, 1);
      wait_mode(pmc_pkg::MODE_ACTIVE, 8);
      rd(pmc_pkg::ADDR_ACT_TMPL, 32'hff);
    end
    $display("test reset sources done");
    // one more edge so the watcher compares the last read
    @(posedge ref_clk);
    stop_test();
  end
endmodule : pmc_power_mode_ctrl_test
`default_nettype wire
